// File: design/periodic_timebase.sv
// Purpose: Periodic timebase with an 18-stage divider and rate taps.
// Assumes: Power mode inputs come from logic on the MCLK domain.
// Notes:   Registers sit behind an AXI4-Lite slave, one word each.
`timescale 1ns/10ps

module periodic_timebase
   import periodic_timebase_pkg::*;
#(
   parameter int REF_DIV = REF_DIV_CYC,
   parameter int CNT_W   = CNT_STAGES
) (
   // Clock and reset.
   input  wire logic        MCLK,
   input  wire logic        RST,
   // AXI4-Lite write address channel.
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   // AXI4-Lite write data channel.
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   // AXI4-Lite write response channel.
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // AXI4-Lite read address channel.
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   // AXI4-Lite read data channel.
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // Power mode state from the system controller.
   input  wire logic        WAIT_MODE,
   input  wire logic        STOP_MODE,
   input  wire logic        OSC_STOP_EN,
   // Interrupt outputs.
   output logic             TB_IRQ,
   output logic             IRQ
);

   // Parameters that the logic cannot serve are refused here.
   // The tick divider is 16 bits wide, which caps REF_DIV.
   if (REF_DIV < 1 || REF_DIV > 65536 || CNT_W != CNT_STAGES)
   begin : g_param_check
      $error("periodic_timebase: unsupported parameter values");
   end

   // Returns which register an address selects.
   function automatic reg_sel_e reg_sel(input logic [7:0] a);
      reg_sel_e s;
      s = SEL_NONE;
      if (a == CTRL_OFS) begin
         s = SEL_CTRL;
      end else if (a == STAT_OFS) begin
         s = SEL_STAT;
      end else if (a == MASK_OFS) begin
         s = SEL_MASK;
      end
      return s;
   endfunction

   // Returns the divider stage watched for a rate code.
   function automatic logic [4:0] tap_of(input logic [2:0] r);
      return TAP_IDX[r];
   endfunction

   // Control fields.
   logic             enable_reg;     // Module enable.
   logic             irq_en_reg;     // Rollover interrupt enable.
   logic [2:0]       rate_reg;       // Rate select code.
   logic             pending_reg;    // Rollover pending flag.
   // System interrupt status and mask.
   logic             evt_stat_reg;   // Sticky rollover event.
   logic             evt_mask_reg;   // Event mask, one passes it.
   // Divider chain and reference tick generator.
   logic [CNT_W-1:0] cnt_reg;        // Divider chain stages.
   logic [CNT_W-1:0] cnt_next;       // Chain value after a step.
   logic [15:0]      div_reg;        // MCLK cycles since last tick.
   logic             ref_tick;       // One reference clock period.
   logic             run;            // Reference clock alive.
   logic             step;           // Chain advances this cycle.
   logic             rollover_evt;   // Selected tap rose.
   logic [4:0]       tap;            // Watched stage index.
   // Write channel holding state.
   logic             aw_hold_reg;    // Write address captured.
   logic [7:0]       awaddr_reg;     // Captured write address.
   logic             w_hold_reg;     // Write data captured.
   logic [31:0]      wdata_reg;      // Captured write data.
   logic             wstrb0_reg;     // Captured low byte strobe.
   logic             bvalid_reg;     // Write response pending.
   logic [1:0]       bresp_reg;      // Write response code.
   logic             wr_fire;        // Write performed this cycle.
   logic             wr_ok;          // Write reaches a register.
   reg_sel_e         wr_sel;         // Register hit by the write.
   // Read channel state.
   logic             rvalid_reg;     // Read data pending.
   logic [31:0]      rdata_reg;      // Read data.
   logic [1:0]       rresp_reg;      // Read response code.
   logic             rd_fire;        // Read address taken.
   // Access gate and acknowledge strobe.
   logic             access_ok;      // CPU may reach the registers.
   logic             ack_clear;      // Acknowledge written as one.

   // Registers are closed to the CPU in wait and stop modes.
   assign access_ok = !WAIT_MODE && !STOP_MODE;

   // The reference clock stops in stop mode unless kept alive.
   assign run = enable_reg && !(STOP_MODE && !OSC_STOP_EN);

   // Reference tick divider; it restarts whenever the block is off
   // so that every enable sees the same first tick spacing.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         div_reg <= 16'h0000;
      end else if (!enable_reg) begin
         div_reg <= 16'h0000;
      end else if (run) begin
         if (ref_tick) begin
            div_reg <= 16'h0000;
         end else begin
            div_reg <= div_reg + 16'h0001;
         end
      end
   end

   // A tick is one MCLK cycle wide at the end of each ref period.
   assign ref_tick = run && (div_reg == 16'(REF_DIV - 1));
   assign step     = ref_tick;

   // Next chain value; the chain wraps at its top stage.
   assign cnt_next = cnt_reg + CNT_W'(1);

   // Divider chain: zero while disabled, counting on each reference tick while enabled.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cnt_reg <= CNT_RST;
      end else if (!enable_reg) begin
         cnt_reg <= CNT_RST;
      end else if (step) begin
         cnt_reg <= cnt_next;
      end
   end

   // Watching the rising edge of the tap gives the first event
   // after half a period from zero, then one per full period.
   assign tap          = tap_of(rate_reg);
   assign rollover_evt = step && cnt_next[tap] && !cnt_reg[tap];

   // Acknowledge strobe: a one written to the write-only bit.
   assign ack_clear = wr_ok && (wr_sel == SEL_CTRL)
                      && wdata_reg[ACK_BIT];

   // Pending flag; a rollover in the acknowledge cycle wins.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pending_reg <= 1'b0;
      end else if (rollover_evt) begin
         pending_reg <= 1'b1;
      end else if (ack_clear) begin
         pending_reg <= 1'b0;
      end
   end

   // Control fields written from the bus.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         enable_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         rate_reg   <= RATE_RST;
      end else if (wr_ok && wr_sel == SEL_CTRL) begin
         enable_reg <= wdata_reg[EN_BIT];
         irq_en_reg <= wdata_reg[IE_BIT];
         // The rate is taken even while running; software is
         // expected to disable first, else one period is odd.
         rate_reg   <= wdata_reg[RATE_LSB +: 3];
      end
   end

   // Sticky system status bit, cleared by writing a one.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         evt_stat_reg <= 1'b0;
      end else if (rollover_evt) begin
         evt_stat_reg <= 1'b1;
      end else if (wr_ok && wr_sel == SEL_STAT
                   && wdata_reg[EVT_BIT]) begin
         evt_stat_reg <= 1'b0;
      end
   end

   // System interrupt mask.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         evt_mask_reg <= 1'b0;
      end else if (wr_ok && wr_sel == SEL_MASK) begin
         evt_mask_reg <= wdata_reg[EVT_BIT];
      end
   end

   // Level requests: the CPU request follows flag and enable.
   assign TB_IRQ = pending_reg && irq_en_reg;
   assign IRQ    = evt_stat_reg && evt_mask_reg;

   // Address and data are taken independently, one of each.
   assign AWREADY = !aw_hold_reg;
   assign WREADY  = !w_hold_reg;
   assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_sel  = reg_sel(awaddr_reg);
   // Only the low byte lane holds fields.
   assign wr_ok   = wr_fire && access_ok && wstrb0_reg
                    && (wr_sel != SEL_NONE);

   // Write address capture.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg  <= 8'h00;
      end else if (AWVALID && !aw_hold_reg) begin
         aw_hold_reg <= 1'b1;
         awaddr_reg  <= AWADDR;
      end else if (wr_fire) begin
         aw_hold_reg <= 1'b0;
      end
   end

   // Write data capture.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         w_hold_reg <= 1'b0;
         wdata_reg  <= 32'h00000000;
         wstrb0_reg <= 1'b0;
      end else if (WVALID && !w_hold_reg) begin
         w_hold_reg <= 1'b1;
         wdata_reg  <= WDATA;
         wstrb0_reg <= WSTRB[0];
      end else if (wr_fire) begin
         w_hold_reg <= 1'b0;
      end
   end

   // Write response; refused accesses answer with an error.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         if (access_ok && wr_sel != SEL_NONE) begin
            bresp_reg <= RESP_OKAY;
         end else begin
            bresp_reg <= RESP_SLVERR;
         end
      end else if (BREADY) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign BVALID = bvalid_reg;
   assign BRESP  = bresp_reg;

   // Read channel; one read at a time, answered next cycle.
   assign ARREADY = !rvalid_reg;
   assign rd_fire = ARVALID && !rvalid_reg;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= RESP_OKAY;
         if (!access_ok) begin
            rresp_reg <= RESP_SLVERR;
         end else begin
            case (reg_sel(ARADDR))
               SEL_CTRL: begin
                  // Acknowledge bit reads back as zero.
                  rdata_reg[EN_BIT]         <= enable_reg;
                  rdata_reg[IE_BIT]         <= irq_en_reg;
                  rdata_reg[RATE_LSB +: 3]  <= rate_reg;
                  rdata_reg[PEND_BIT]       <= pending_reg;
               end
               SEL_STAT: begin
                  rdata_reg[EVT_BIT] <= evt_stat_reg;
               end
               SEL_MASK: begin
                  rdata_reg[EVT_BIT] <= evt_mask_reg;
               end
               default: begin
                  rresp_reg <= RESP_SLVERR;
               end
            endcase
         end
      end else if (RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign RVALID = rvalid_reg;
   assign RDATA  = rdata_reg;
   assign RRESP  = rresp_reg;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   // An acknowledge with no rollover in the same cycle.
   sequence s_ack_only;
      ack_clear && !rollover_evt;
   endsequence

   // A chain step while enabled.
   sequence s_step;
      step && enable_reg;
   endsequence

   chk_cnt_held_zero: assert property (
      !enable_reg && !$past(enable_reg) |-> cnt_reg == CNT_RST)
      else $error("counter not zero while disabled");

   chk_cnt_steps: assert property (
      s_step |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
      else $error("counter did not advance on a tick");

   chk_flag_sets: assert property (
      rollover_evt |=> pending_reg)
      else $error("rollover did not set the flag");

   chk_flag_cause: assert property (
      $rose(pending_reg) |-> $past(rollover_evt))
      else $error("flag set without a rollover");

   chk_ack_clears: assert property (
      s_ack_only |=> !pending_reg)
      else $error("acknowledge did not clear the flag");

   chk_irq_holds: assert property (
      TB_IRQ && !ack_clear && !(wr_ok && wr_sel == SEL_CTRL)
      |=> TB_IRQ)
      else $error("request dropped without a clear");

   chk_irq_follows: assert property (
      rollover_evt && irq_en_reg && !(wr_ok && wr_sel == SEL_CTRL)
      |=> TB_IRQ)
      else $error("no request after an enabled rollover");

   chk_ack_reads_0: assert property (
      rvalid_reg |-> !rdata_reg[ACK_BIT])
      else $error("acknowledge bit read back as one");

   chk_half_period: assert property (
      step |-> rollover_evt ==
         ((cnt_next & ((CNT_W'(2) << tap) - CNT_W'(1)))
          == (CNT_W'(1) << tap)))
      else $error("event not on the tap rising edge");

   chk_bus_blocked: assert property (
      wr_fire && !access_ok
      |=> $stable(enable_reg) && $stable(rate_reg)
          && bresp_reg == RESP_SLVERR)
      else $error("register written in a low power mode");

   chk_stop_idle: assert property (
      STOP_MODE && !OSC_STOP_EN |=> $stable(cnt_reg))
      else $error("chain moved in stop without oscillator");

endmodule

// File: design/periodic_timebase_pkg.sv
// Purpose: Shared constants for the periodic timebase block.
// Assumes: A 10 MHz MCLK and a 32.768 kHz nominal reference rate.
// Notes:   Offsets are byte addresses on the AXI4-Lite register bus.
package periodic_timebase_pkg;

   // Clock and reference timing, in nanoseconds.
   localparam int MCLK_PERIOD_NS = 100;
   localparam int REF_PERIOD_NS  = 30518;
   // Reference tick spacing in MCLK cycles, rounded down.
   localparam int REF_DIV_CYC    = REF_PERIOD_NS / MCLK_PERIOD_NS;

   // Divider chain length.
   localparam int CNT_STAGES = 18;

   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;

   // Control register field positions.
   localparam int EN_BIT    = 1;
   localparam int IE_BIT    = 2;
   localparam int ACK_BIT   = 3;
   localparam int RATE_LSB  = 4;
   localparam int PEND_BIT  = 7;
   // Status and mask register field position.
   localparam int EVT_BIT   = 0;

   // Reset values.
   localparam logic [2:0]  RATE_RST = 3'h0;
   localparam logic [17:0] CNT_RST  = 18'h00000;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Stage index whose rising edge marks an event, per rate code.
   // A tap of index k gives a division ratio of two to the k+1.
   localparam logic [4:0] TAP_IDX [8] = '{
      5'h11, 5'h10, 5'h0F, 5'h0E, 5'h05, 5'h04, 5'h03, 5'h02
   };

   // Register selection decoded from an address.
   typedef enum {SEL_CTRL, SEL_STAT, SEL_MASK, SEL_NONE} reg_sel_e;

endpackage

// File: tb/cpu_irq_model.sv
// Purpose: CPU interrupt input model that stamps each new request.
// Assumes: The request is a level on the MCLK domain.
// Notes:   Only rising edges count, as a level stays up until served.
`timescale 1ns/10ps
module cpu_irq_model (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst,
   // Request from the timebase.
   input  wire logic req,
   // Edge count, free cycle count and stamp of the last edge.
   output int        n_rise,
   output int        cyc,
   output int        stamp
);
   logic req_d;  // Request on the previous edge.

   // A new request is taken once, at its rising edge.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_d  <= 1'b0;
         n_rise <= 0;
         cyc    <= 0;
         stamp  <= 0;
      end else begin
         cyc   <= cyc + 1;
         req_d <= req;
         if (req && !req_d) begin
            n_rise <= n_rise + 1;
            stamp  <= cyc;
         end
      end
   end
endmodule

// File: tb/periodic_timebase_interrupt_test.sv
// Purpose: Self-checking bench for the periodic timebase.
// Assumes: REF_DIV is shortened to 2 so the fast rates run quickly.
// Notes:   The slow rates are checked by readback only.
`timescale 1ns/10ps
module periodic_timebase_interrupt_test;
   import periodic_timebase_pkg::*;
   localparam int RD = 2;  // Short reference divider.
   logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TB_IRQ, IRQ;
   logic WAIT_MODE, STOP_MODE, OSC_STOP_EN;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   int n_errors, checks_done, n_rise, cyc, stamp;
   int s1, s2, e, c0, st, r;
   logic [31:0] d;
   logic [7:0] a;

   periodic_timebase #(.REF_DIV(RD)) uut (.MCLK(MCLK), .RST(RST),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE),
      .OSC_STOP_EN(OSC_STOP_EN), .TB_IRQ(TB_IRQ), .IRQ(IRQ));
   cpu_irq_model cpu (.clk(MCLK), .rst(RST), .req(TB_IRQ),
      .n_rise(n_rise), .cyc(cyc), .stamp(stamp));

   // Free-running 10 MHz clock.
   initial MCLK = 1'b0;
   always #50 MCLK = ~MCLK;

   // Division ratio per rate code, written out independently.
   function automatic int ratio(input int k);
      int t[8] = '{262144, 131072, 65536, 32768, 64, 32, 16, 8};
      return t[k];
   endfunction

   task automatic results;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, x, input string m);
      checks_done++;
      if (s !== x) begin
         n_errors++;
         $display("Error %0t: %s seen %h expected %h", $time, m, s, x);
      end
   endtask

   // A spent wait bound counts as a mismatch and ends the run.
   task automatic hang(input string m);
      n_errors++;
      $display("Error %0t: %s timed out", $time, m);
      results();
   endtask

   // One write; address and data are offered together.
   task automatic w(input logic [7:0] ad, input logic [31:0] dt,
                    input logic [1:0] er);
      bit aw, wd, dn;
      aw = 0; wd = 0; dn = 0;
      AWADDR <= ad; WDATA <= dt; AWVALID <= 1; WVALID <= 1;
      for (int i = 0; !dn; i++) begin
         @(posedge MCLK);
         if (i > 60) hang("write");
         if (aw && wd && BVALID) begin
            dn = 1; BREADY <= 0; chk(BRESP, er, "bresp");
         end
         if (!aw && AWREADY) begin aw = 1; AWVALID <= 0; end
         if (!wd && WREADY) begin wd = 1; WVALID <= 0; end
         // Response ready is raised once both halves are taken.
         if (aw && wd && !dn) BREADY <= 1;
      end
   endtask

   // One read, compared with the expected word and response.
   task automatic rv(input logic [7:0] ad, input logic [31:0] ex,
                     input logic [1:0] er);
      bit ar, dn;
      ar = 0; dn = 0;
      ARADDR <= ad; ARVALID <= 1;
      for (int i = 0; !dn; i++) begin
         @(posedge MCLK);
         if (i > 60) hang("read");
         if (ar && RVALID) begin
            dn = 1; RREADY <= 0;
            chk(RDATA, ex, "rdata"); chk(RRESP, er, "rresp");
         end
         if (!ar && ARREADY) begin ar = 1; ARVALID <= 0; RREADY <= 1; end
      end
   endtask

   // Waits for the next new request; the stamp comes back in sp.
   task automatic wirq(output int sp);
      int k;
      k = n_rise;
      for (int i = 0; n_rise == k; i++) begin
         @(posedge MCLK);
         if (i > 3000) hang("request");
      end
      sp = stamp;
   endtask

   initial begin
      RST = 1; AWVALID = 0; WVALID = 0; BREADY = 0;
      ARVALID = 0; RREADY = 0; AWADDR = 8'h00; ARADDR = 8'h00;
      WDATA = 32'h0; WSTRB = 4'hF; WAIT_MODE = 0; STOP_MODE = 0;
      OSC_STOP_EN = 0; n_errors = 0; checks_done = 0;
      d = $urandom(32'h8F6C);
      repeat (12) @(posedge MCLK);
      RST <= 0;
      @(posedge MCLK);
      rv(CTRL_OFS, 32'h0, RESP_OKAY);
      rv(STAT_OFS, 32'h0, RESP_OKAY);
      rv(MASK_OFS, 32'h0, RESP_OKAY);
      $display("test reset values done");
      for (int k = 0; k < 4; k++) begin
         a = 8'($urandom_range(3, 63) * 4);
         w(a, $urandom, RESP_SLVERR);
         rv(a, 32'h0, RESP_SLVERR);
         d = $urandom;
         w(MASK_OFS, d, RESP_OKAY);
         rv(MASK_OFS, {31'h0, d[0]}, RESP_OKAY);
      end
      // A write without the low byte lane leaves the mask alone.
      WSTRB <= 4'hE;
      w(MASK_OFS, ~d, RESP_OKAY);
      WSTRB <= 4'hF;
      rv(MASK_OFS, {31'h0, d[0]}, RESP_OKAY);
      w(CTRL_OFS, 32'h88, RESP_OKAY);
      rv(CTRL_OFS, 32'h0, RESP_OKAY);
      for (int k = 0; k < 8; k++) begin
         w(CTRL_OFS, k << 4, RESP_OKAY);
         rv(CTRL_OFS, k << 4, RESP_OKAY);
      end
      w(CTRL_OFS, 32'h0, RESP_OKAY);
      $display("test register access done");
      // Fast rates in turn from a random starting code, each from a fresh enable.
      st = $urandom_range(0, 3);
      for (int j = 0; j < 4; j++) begin
         r = 4 + (j + st) % 4;
         w(CTRL_OFS, (r << 4) | 6, RESP_OKAY);
         e = cyc;
         wirq(s1);
         chk((s1 - e - ratio(r) / 2 * RD) inside {[-6 : 6]}, 1, "first");
         w(CTRL_OFS, (r << 4) | 32'hE, RESP_OKAY);
         rv(CTRL_OFS, (r << 4) | 6, RESP_OKAY);
         wirq(s2);
         chk(s2 - s1, ratio(r) * RD, "period");
         @(posedge MCLK);
         chk(TB_IRQ, 1, "level");
         w(CTRL_OFS, (r << 4) | 2, RESP_OKAY);
         chk(TB_IRQ, 0, "gated");
         rv(CTRL_OFS, (r << 4) | 32'h82, RESP_OKAY);
         w(CTRL_OFS, r << 4, RESP_OKAY);
         // Fastest rate and request enable left on while disabled,
         // so a counter that kept running would raise a request.
         w(CTRL_OFS, 32'h7C, RESP_OKAY);
         rv(CTRL_OFS, 32'h74, RESP_OKAY);
         c0 = n_rise;
         repeat (40) @(posedge MCLK);
         chk(n_rise, c0, "idle");
      end
      $display("test rates done");
      rv(STAT_OFS, 32'h1, RESP_OKAY);
      w(MASK_OFS, 32'h1, RESP_OKAY);
      chk(IRQ, 1, "masked on");
      w(MASK_OFS, 32'h0, RESP_OKAY);
      chk(IRQ, 0, "masked off");
      w(STAT_OFS, 32'h1, RESP_OKAY);
      rv(STAT_OFS, 32'h0, RESP_OKAY);
      $display("test status done");
      w(CTRL_OFS, 32'h76, RESP_OKAY);
      WAIT_MODE <= 1;
      rv(CTRL_OFS, 32'h0, RESP_SLVERR);
      w(CTRL_OFS, 32'h0, RESP_SLVERR);
      wirq(s1);
      WAIT_MODE <= 0;
      rv(CTRL_OFS, 32'hF6, RESP_OKAY);
      w(CTRL_OFS, 32'h7E, RESP_OKAY);
      OSC_STOP_EN <= 1;
      STOP_MODE <= 1;
      wirq(s1);
      STOP_MODE <= 0;
      w(CTRL_OFS, 32'h7E, RESP_OKAY);
      OSC_STOP_EN <= 0;
      STOP_MODE <= 1;
      repeat (2) @(posedge MCLK);
      c0 = n_rise;
      repeat (100) @(posedge MCLK);
      chk(n_rise, c0, "frozen");
      rv(CTRL_OFS, 32'h0, RESP_SLVERR);
      STOP_MODE <= 0;
      wirq(s1);
      w(CTRL_OFS, 32'h0, RESP_OKAY);
      rv(CTRL_OFS, 32'h80, RESP_OKAY);
      w(CTRL_OFS, 32'hC, RESP_OKAY);
      chk(TB_IRQ, 0, "acked");
      $display("test power modes done");
      results();
   end
endmodule
